// ==== src/mode_three_config_regs.sv ====
// Purpose: Mode setting 3 configuration registers and their effect on the rails
// Assumes: Register port comes from the serial target engine, synchronous to clk
// Notes: Rail outputs are zero from one cycle after another mode setting becomes active
`timescale 1ns/1ps

module mode_three_config_regs
  import mode_three_cfg_pkg::*;
#(
  parameter int FILTER_CYCLES = BUTTON_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Mode selection
  input wire logic modeSourcePinSelect,
  input wire logic modeSelectPinA,
  input wire logic modeSelectPinB,
  input wire logic [1:0] modeInternalBits,
  output logic [1:0] activeMode,
  output logic modeThreeActive,
  // Power button
  input wire logic buttonPin,
  output logic buttonDebouncedLevel,
  // Rail controls
  output logic coreBuckEnable,
  output logic systemBuckEnable,
  output logic aonRegulatorEnable,
  output logic systemRegulatorEnable,
  output logic [11:0] systemBuckMillivolts,
  output logic [11:0] aonRegulatorMillivolts,
  output logic [11:0] systemRegulatorMillivolts,
  output logic [1:0] watchdogPeriodSel
);

  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [1:0] mode;
    logic [1:0] prevRequest;
    logic [7:0] rdData;
    logic modeThree;
    logic coreEn;
    logic buckEn;
    logic aonEn;
    logic regEn;
    logic [11:0] buckMv;
    logic [11:0] aonMv;
    logic [11:0] regMv;
    logic [1:0] wdSel;
  } regs_t;

  localparam regs_t RESET_STATE = '{
    cfg1: MODE3_BUTTON_AND_BUCK2_CFG_RESET,
    cfg2: MODE3_AON_VOLT_AND_ENABLES_RESET,
    cfg3: MODE3_WATCHDOG_AND_SYSREG_CFG_RESET,
    default: '0
  };

  regs_t s;
  regs_t next_s;
  logic buttonFall;
  logic [1:0] modeRequest;

  ////////////////////////////////////////////////////////////////////////////

  button_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) buttonFilter (
    .clk(clk),
    .rst(rst),
    .buttonPin(buttonPin),
    .buttonDebouncedLevel(buttonDebouncedLevel),
    .buttonFallPulse(buttonFall)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Five-bit rail code to millivolts, with offset
  function automatic logic [11:0] fiveBitRailMv(input logic [4:0] code, input logic offsetSel);
    logic [4:0] sat;
    sat = (code > FIVE_BIT_RAIL_TOP_CODE) ? FIVE_BIT_RAIL_TOP_CODE : code;
    return FIVE_BIT_RAIL_BASE_MV + 12'(sat) * RAIL_STEP_MV +
      (offsetSel ? RAIL_OFFSET_MV : 12'h000);
  endfunction

  // Four-bit always-on code to millivolts
  function automatic logic [11:0] aonRailMv(input logic [3:0] code);
    logic [3:0] sat;
    sat = (code > AON_RAIL_TOP_CODE) ? AON_RAIL_TOP_CODE : code;
    return AON_RAIL_BASE_MV + 12'(sat) * RAIL_STEP_MV;
  endfunction

  // Mode request source
  assign modeRequest = modeSourcePinSelect ? {modeSelectPinB, modeSelectPinA}
                                           : modeInternalBits;

  always_comb begin
    next_s = s;
    // Register writes
    if (regWrite) begin
      unique case (regAddr)
        MODE3_BUTTON_AND_BUCK2_CFG_ADDR: next_s.cfg1 = regWrData;
        MODE3_AON_VOLT_AND_ENABLES_ADDR: next_s.cfg2 = regWrData;
        MODE3_WATCHDOG_AND_SYSREG_CFG_ADDR: next_s.cfg3 = regWrData;
        default: ;
      endcase
    end
    // Register reads, unmapped reads zero
    if (regRead) begin
      unique case (regAddr)
        MODE3_BUTTON_AND_BUCK2_CFG_ADDR: next_s.rdData = s.cfg1;
        MODE3_AON_VOLT_AND_ENABLES_ADDR: next_s.rdData = s.cfg2;
        MODE3_WATCHDOG_AND_SYSREG_CFG_ADDR: next_s.rdData = s.cfg3;
        default: next_s.rdData = UNMAPPED_READ_VALUE;
      endcase
    end
    // Mode tracking; button fall takes priority over a new request
    next_s.prevRequest = modeRequest;
    if (buttonFall && s.mode == MODE_SETTING_3 && !s.cfg1[BUTTON_EDGE_CFG_BIT]) begin
      next_s.mode = MODE_SETTING_0;
    end else if (modeRequest != s.prevRequest) begin
      next_s.mode = modeRequest;
    end
    // Rail controls follow registers only in mode 3
    next_s.modeThree = (s.mode == MODE_SETTING_3);
    if (s.mode == MODE_SETTING_3) begin
      next_s.coreEn = s.cfg2[CORE_BUCK_ENABLE_BIT];
      next_s.buckEn = s.cfg2[SYSTEM_BUCK_ENABLE_BIT];
      next_s.aonEn = s.cfg2[AON_REGULATOR_ENABLE_BIT];
      next_s.regEn = s.cfg2[SYSTEM_REGULATOR_ENABLE_BIT];
      next_s.buckMv = fiveBitRailMv(
        s.cfg1[SYSTEM_BUCK_VOLTAGE_CODE_MSB:SYSTEM_BUCK_VOLTAGE_CODE_LSB],
        s.cfg1[SYSTEM_BUCK_OFFSET_SEL_BIT]);
      next_s.aonMv = aonRailMv(
        s.cfg2[AON_REGULATOR_VOLTAGE_CODE_MSB:AON_REGULATOR_VOLTAGE_CODE_LSB]);
      next_s.regMv = fiveBitRailMv(
        s.cfg3[SYSTEM_REGULATOR_VOLTAGE_CODE_MSB:SYSTEM_REGULATOR_VOLTAGE_CODE_LSB],
        s.cfg3[SYSTEM_REGULATOR_OFFSET_SEL_BIT]);
      next_s.wdSel = s.cfg3[WATCHDOG_PERIOD_SEL_MSB:WATCHDOG_PERIOD_SEL_LSB];
    end else begin
      next_s.coreEn = 1'b0;
      next_s.buckEn = 1'b0;
      next_s.aonEn = 1'b0;
      next_s.regEn = 1'b0;
      next_s.buckMv = 12'h000;
      next_s.aonMv = 12'h000;
      next_s.regMv = 12'h000;
      next_s.wdSel = WATCHDOG_DISABLED;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign regRdData = s.rdData;
  assign activeMode = s.mode;
  assign modeThreeActive = s.modeThree;
  assign coreBuckEnable = s.coreEn;
  assign systemBuckEnable = s.buckEn;
  assign aonRegulatorEnable = s.aonEn;
  assign systemRegulatorEnable = s.regEn;
  assign systemBuckMillivolts = s.buckMv;
  assign aonRegulatorMillivolts = s.aonMv;
  assign systemRegulatorMillivolts = s.regMv;
  assign watchdogPeriodSel = s.wdSel;

  ////////////////////////////////////////////////////////////////////////////

  AST_PART1_WRITE_READ: assert property (
    @(posedge clk) disable iff (rst)
    regWrite && regAddr == MODE3_BUTTON_AND_BUCK2_CFG_ADDR ##1
    regRead && regAddr == MODE3_BUTTON_AND_BUCK2_CFG_ADDR && !regWrite
    |=> regRdData == $past(regWrData, 2))
    else $error("Part 1 readback differs from written value");

  AST_PART2_WRITE_READ: assert property (
    @(posedge clk) disable iff (rst)
    regWrite && regAddr == MODE3_AON_VOLT_AND_ENABLES_ADDR ##1
    regRead && regAddr == MODE3_AON_VOLT_AND_ENABLES_ADDR && !regWrite
    |=> regRdData == $past(regWrData, 2))
    else $error("Part 2 readback differs from written value");

  AST_PART3_WRITE_READ: assert property (
    @(posedge clk) disable iff (rst)
    regWrite && regAddr == MODE3_WATCHDOG_AND_SYSREG_CFG_ADDR ##1
    regRead && regAddr == MODE3_WATCHDOG_AND_SYSREG_CFG_ADDR && !regWrite
    |=> regRdData == $past(regWrData, 2))
    else $error("Part 3 readback differs from written value");

  AST_BUTTON_TO_MODE0: assert property (
    @(posedge clk) disable iff (rst)
    buttonFall && activeMode == MODE_SETTING_3 && !s.cfg1[BUTTON_EDGE_CFG_BIT]
    |=> activeMode == MODE_SETTING_0 ##1 !modeThreeActive)
    else $error("Button fall did not return to mode 0");

  AST_BUTTON_IGNORED: assert property (
    @(posedge clk) disable iff (rst)
    buttonFall && s.cfg1[BUTTON_EDGE_CFG_BIT] && modeRequest == s.prevRequest
    |=> $stable(activeMode))
    else $error("Button fall changed mode while configured to be ignored");

  AST_PIN_SOURCE: assert property (
    @(posedge clk) disable iff (rst)
    !buttonFall && modeSourcePinSelect && modeRequest != s.prevRequest
    |=> activeMode == $past({modeSelectPinB, modeSelectPinA}))
    else $error("Mode did not follow the select pins");

  AST_BUCK_VOLTAGE: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3 && s.cfg1[SYSTEM_BUCK_OFFSET_SEL_BIT] &&
      s.cfg1[SYSTEM_BUCK_VOLTAGE_CODE_MSB:SYSTEM_BUCK_VOLTAGE_CODE_LSB] == FIVE_BIT_RAIL_TOP_CODE
    |=> systemBuckMillivolts == 12'hCE4)
    else $error("System buck top code with offset is not 3.3 V");

  AST_REG_SATURATE: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3 && !s.cfg3[SYSTEM_REGULATOR_OFFSET_SEL_BIT] &&
      s.cfg3[SYSTEM_REGULATOR_VOLTAGE_CODE_MSB:SYSTEM_REGULATOR_VOLTAGE_CODE_LSB]
      > FIVE_BIT_RAIL_TOP_CODE
    |=> systemRegulatorMillivolts == 12'h834)
    else $error("System regulator code above top did not saturate at 2.1 V");

  AST_AON_VOLTAGE: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3
    |=> aonRegulatorMillivolts >= AON_RAIL_BASE_MV && aonRegulatorMillivolts <= 12'h76C)
    else $error("Always-on regulator voltage out of range");

  AST_ENABLES_FOLLOW: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3 |=> {coreBuckEnable, systemBuckEnable, aonRegulatorEnable,
      systemRegulatorEnable} == $past(s.cfg2[CORE_BUCK_ENABLE_BIT:SYSTEM_REGULATOR_ENABLE_BIT]))
    else $error("Rail enables do not follow part 2");

  AST_WATCHDOG_FOLLOW: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3 && s.cfg3[WATCHDOG_PERIOD_SEL_MSB:WATCHDOG_PERIOD_SEL_LSB]
      == WATCHDOG_64S |=> watchdogPeriodSel == WATCHDOG_64S)
    else $error("Watchdog period does not follow part 3");

  AST_OTHER_MODE_QUIET: assert property (
    @(posedge clk) disable iff (rst)
    activeMode != MODE_SETTING_3 |=> !modeThreeActive && !coreBuckEnable &&
      systemBuckMillivolts == 12'h000 && watchdogPeriodSel == WATCHDOG_DISABLED)
    else $error("Rail controls driven outside mode 3");

  AST_BUCK_OFFSET_ON: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3 && s.cfg1[SYSTEM_BUCK_OFFSET_SEL_BIT]
    |=> systemBuckMillivolts >= 12'hA8C && systemBuckMillivolts <= 12'hCE4)
    else $error("System buck offset did not raise the voltage");

  AST_BUCK_OFFSET_OFF: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3 && !s.cfg1[SYSTEM_BUCK_OFFSET_SEL_BIT]
    |=> systemBuckMillivolts >= FIVE_BIT_RAIL_BASE_MV && systemBuckMillivolts <= 12'h834)
    else $error("System buck voltage out of range without offset");

  AST_REG_OFFSET_ON: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3 && s.cfg3[SYSTEM_REGULATOR_OFFSET_SEL_BIT]
    |=> systemRegulatorMillivolts >= 12'hA8C && systemRegulatorMillivolts <= 12'hCE4)
    else $error("System regulator offset did not raise the voltage");

  AST_AON_SATURATE: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3 &&
      s.cfg2[AON_REGULATOR_VOLTAGE_CODE_MSB:AON_REGULATOR_VOLTAGE_CODE_LSB] > AON_RAIL_TOP_CODE
    |=> aonRegulatorMillivolts == 12'h76C)
    else $error("Always-on regulator code above top did not saturate at 1.9 V");

  AST_INTERNAL_SOURCE: assert property (
    @(posedge clk) disable iff (rst)
    !buttonFall && !modeSourcePinSelect && modeRequest != s.prevRequest
    |=> activeMode == $past(modeInternalBits))
    else $error("Mode did not follow the internal bits");

  AST_MODE3_FLAG: assert property (
    @(posedge clk) disable iff (rst)
    activeMode == MODE_SETTING_3 |=> modeThreeActive)
    else $error("Mode 3 flag not raised one cycle after mode 3");

endmodule // mode_three_config_regs

// ==== src/mode_three_cfg_pkg.sv ====
// Purpose: Shared constants for the mode setting 3 configuration registers
// Assumes: 40 MHz internal digital clock
// Notes: Offsets are the register-port byte addresses
package mode_three_cfg_pkg;

  // Register offsets
  localparam logic [7:0] MODE3_BUTTON_AND_BUCK2_CFG_ADDR = 8'h2F;
  localparam logic [7:0] MODE3_AON_VOLT_AND_ENABLES_ADDR = 8'h30;
  localparam logic [7:0] MODE3_WATCHDOG_AND_SYSREG_CFG_ADDR = 8'h31;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // Reset values
  localparam logic [7:0] MODE3_BUTTON_AND_BUCK2_CFG_RESET = 8'h4C;
  localparam logic [7:0] MODE3_AON_VOLT_AND_ENABLES_RESET = 8'h4F;
  localparam logic [7:0] MODE3_WATCHDOG_AND_SYSREG_CFG_RESET = 8'h0C;

  // Field positions, part 1
  localparam int BUTTON_EDGE_CFG_BIT = 6;
  localparam int SYSTEM_BUCK_OFFSET_SEL_BIT = 5;
  localparam int SYSTEM_BUCK_VOLTAGE_CODE_MSB = 4;
  localparam int SYSTEM_BUCK_VOLTAGE_CODE_LSB = 0;
  // Field positions, part 2
  localparam int AON_REGULATOR_VOLTAGE_CODE_MSB = 7;
  localparam int AON_REGULATOR_VOLTAGE_CODE_LSB = 4;
  localparam int CORE_BUCK_ENABLE_BIT = 3;
  localparam int SYSTEM_BUCK_ENABLE_BIT = 2;
  localparam int AON_REGULATOR_ENABLE_BIT = 1;
  localparam int SYSTEM_REGULATOR_ENABLE_BIT = 0;
  // Field positions, part 3
  localparam int WATCHDOG_PERIOD_SEL_MSB = 7;
  localparam int WATCHDOG_PERIOD_SEL_LSB = 6;
  localparam int SYSTEM_REGULATOR_OFFSET_SEL_BIT = 5;
  localparam int SYSTEM_REGULATOR_VOLTAGE_CODE_MSB = 4;
  localparam int SYSTEM_REGULATOR_VOLTAGE_CODE_LSB = 0;

  // Mode settings
  localparam logic [1:0] MODE_SETTING_0 = 2'h0;
  localparam logic [1:0] MODE_SETTING_3 = 2'h3;

  // Watchdog period encodings
  localparam logic [1:0] WATCHDOG_DISABLED = 2'h0;
  localparam logic [1:0] WATCHDOG_16S = 2'h1;
  localparam logic [1:0] WATCHDOG_32S = 2'h2;
  localparam logic [1:0] WATCHDOG_64S = 2'h3;

  // Voltage mapping in millivolts
  localparam logic [11:0] RAIL_STEP_MV = 12'h019;
  localparam logic [11:0] RAIL_OFFSET_MV = 12'h4B0;
  localparam logic [11:0] FIVE_BIT_RAIL_BASE_MV = 12'h5DC;
  localparam logic [4:0] FIVE_BIT_RAIL_TOP_CODE = 5'h18;
  localparam logic [11:0] AON_RAIL_BASE_MV = 12'h6A4;
  localparam logic [3:0] AON_RAIL_TOP_CODE = 4'h8;

  // Button low-level filter time
  localparam int CLK_HZ = 40_000_000;
  localparam int BUTTON_FILTER_MS = 5;
  localparam int BUTTON_FILTER_CYCLES = BUTTON_FILTER_MS * (CLK_HZ / 1000);

endpackage

// ==== src/button_filter.sv ====
// Purpose: Low-level filter and falling-edge detector for the power button
// Assumes: buttonPin is synchronous to clk
// Notes: High level passes at once, low level only after FILTER_CYCLES
`timescale 1ns/1ps
module button_filter
  import mode_three_cfg_pkg::*;
#(
  parameter int FILTER_CYCLES = BUTTON_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Button pin and filtered result
  input wire logic buttonPin,
  output logic buttonDebouncedLevel,
  output logic buttonFallPulse
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic level;
    logic fall;
  } filter_state_t;

  filter_state_t s;
  filter_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.fall = 1'b0;
    if (buttonPin) begin
      next_s.level = 1'b1;
      next_s.count = '0;
    end else if (s.level) begin
      if (s.count == CW'(FILTER_CYCLES - 1)) begin
        next_s.level = 1'b0;
        next_s.fall = 1'b1;
        next_s.count = '0;
      end else begin
        next_s.count = s.count + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{count: '0, level: 1'b1, fall: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign buttonDebouncedLevel = s.level;
  assign buttonFallPulse = s.fall;

  AST_HIGH_PASSES: assert property (
    @(posedge clk) disable iff (rst) buttonPin |=> buttonDebouncedLevel)
    else $error("High button level did not pass at once");

  AST_LOW_FILTERED: assert property (
    @(posedge clk) disable iff (rst)
    $rose(buttonFallPulse) |-> $past(s.count) == CW'(FILTER_CYCLES - 1) && !$past(buttonPin))
    else $error("Button fall without full low filter time");

endmodule // button_filter

// ==== tb/reg_host_model.sv ====
// Purpose: Host side of the register port, issuing single byte reads and writes
// Assumes: Requests launched just after a rising edge, held through the taking edge
// Notes: Address and data lines show inverted values while released
`timescale 1ns/1ps
module reg_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'hFF;
    regWrData = 8'hFF;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    regAddr <= addr;
    regWrData <= data;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~addr;
    regWrData <= ~data;
  endtask

  task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    regAddr <= addr;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~addr;
    @(negedge clk);
    data = regRdData;
  endtask

  // Write, then read the same address on the very next edge
  task automatic writeRead(input logic [7:0] addr, input logic [7:0] data,
    output logic [7:0] rdBack);
    @(posedge clk);
    regAddr <= addr;
    regWrData <= data;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regWrData <= ~data;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~addr;
    @(negedge clk);
    rdBack = regRdData;
  endtask
endmodule // reg_host_model

// ==== tb/tb_mode_three_config_regs.sv ====
// Purpose: Self-checking bench for the mode setting 3 configuration registers
// Assumes: Short button filter of 8 cycles in simulation
// Notes: Register traffic goes through the host model tasks
`timescale 1ns/1ps
module tb_mode_three_config_regs;
  import mode_three_cfg_pkg::*;
  localparam int FILT = 8;
  localparam int LIMIT = 5000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, rd;
  logic regWrite, regRead;
  logic modeSourcePinSelect = 1'b0;
  logic modeSelectPinA = 1'b0;
  logic modeSelectPinB = 1'b0;
  logic [1:0] modeInternalBits = 2'h0;
  logic buttonPin = 1'b1;
  logic [1:0] activeMode, watchdogPeriodSel;
  logic modeThreeActive, buttonDebouncedLevel;
  logic coreBuckEnable, systemBuckEnable, aonRegulatorEnable, systemRegulatorEnable;
  logic [11:0] systemBuckMillivolts, aonRegulatorMillivolts, systemRegulatorMillivolts;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  reg_host_model reg_host_model_i (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));

  mode_three_config_regs #(.FILTER_CYCLES(FILT)) mode_three_config_regs_i (.clk(clk),
    .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .modeSourcePinSelect(modeSourcePinSelect),
    .modeSelectPinA(modeSelectPinA), .modeSelectPinB(modeSelectPinB),
    .modeInternalBits(modeInternalBits), .activeMode(activeMode),
    .modeThreeActive(modeThreeActive), .buttonPin(buttonPin),
    .buttonDebouncedLevel(buttonDebouncedLevel), .coreBuckEnable(coreBuckEnable),
    .systemBuckEnable(systemBuckEnable), .aonRegulatorEnable(aonRegulatorEnable),
    .systemRegulatorEnable(systemRegulatorEnable),
    .systemBuckMillivolts(systemBuckMillivolts),
    .aonRegulatorMillivolts(aonRegulatorMillivolts),
    .systemRegulatorMillivolts(systemRegulatorMillivolts),
    .watchdogPeriodSel(watchdogPeriodSel));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      test_done();
    end
  end

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
    reg_host_model_i.readReg(addr, rd);
    check({4'h0, rd}, {4'h0, exp});
  endtask

  task automatic setMode(input logic sel, input logic a, input logic b, input logic [1:0] ib);
    @(posedge clk);
    modeSourcePinSelect <= sel;
    modeSelectPinA <= a;
    modeSelectPinB <= b;
    modeInternalBits <= ib;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic chkRails(input logic [3:0] en, input int buck, input int aon, input int sreg,
    input logic [1:0] wd);
    check({8'h0, coreBuckEnable, systemBuckEnable, aonRegulatorEnable,
      systemRegulatorEnable}, {8'h0, en});
    check(systemBuckMillivolts, 12'(buck));
    check(aonRegulatorMillivolts, 12'(aon));
    check(systemRegulatorMillivolts, 12'(sreg));
    check({10'h0, watchdogPeriodSel}, {10'h0, wd});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rdChk(8'h2F, 8'h4C);
    rdChk(8'h30, 8'h4F);
    rdChk(8'h31, 8'h0C);
    rdChk(8'h2E, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_rw();
    reg_host_model_i.writeReg(8'h2F, 8'hB3);
    reg_host_model_i.writeReg(8'h30, 8'h5A);
    reg_host_model_i.writeReg(8'h31, 8'hE7);
    reg_host_model_i.writeReg(8'h2E, 8'hFF);
    rdChk(8'h2F, 8'hB3);
    rdChk(8'h30, 8'h5A);
    rdChk(8'h31, 8'hE7);
    rdChk(8'h2E, 8'h00);
    $display("test_rw done");
  endtask

  task automatic test_back_to_back();
    reg_host_model_i.writeRead(8'h2F, 8'hA5, rd);
    check({4'h0, rd}, 12'h0A5);
    reg_host_model_i.writeRead(8'h30, 8'h3C, rd);
    check({4'h0, rd}, 12'h03C);
    reg_host_model_i.writeRead(8'h31, 8'h96, rd);
    check({4'h0, rd}, 12'h096);
    $display("test_back_to_back done");
  endtask

  task automatic test_pending();
    reg_host_model_i.writeReg(8'h30, 8'h8A);
    reg_host_model_i.writeReg(8'h2F, 8'h4C);
    reg_host_model_i.writeReg(8'h31, 8'h0C);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chkRails(4'h0, 0, 0, 0, 2'h0);
    setMode(1'b1, 1'b1, 1'b1, 2'h0);
    check({10'h0, activeMode}, 12'h003);
    check({11'h0, modeThreeActive}, 12'h001);
    chkRails(4'hA, 1800, 1900, 1800, 2'h0);
    $display("test_pending done");
  endtask

  task automatic test_volts();
    logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h0C, 5'h18, 5'h19, 5'h1F};
    logic [4:0] c;
    logic off;
    int lim;
    for (int i = 0; i < 12; i++) begin
      c = codes[i % 6];
      off = i[0];
      lim = (c > 24) ? 24 : c;
      reg_host_model_i.writeReg(8'h2F, {2'b01, off, c});
      reg_host_model_i.writeReg(8'h30, {c[3:0], c[3:0]});
      reg_host_model_i.writeReg(8'h31, {2'(i), ~off, c});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chkRails(c[3:0], 1500 + 25 * lim + 1200 * off,
        1700 + 25 * ((c[3:0] > 8) ? 8 : c[3:0]),
        1500 + 25 * lim + 1200 * (1 - off), 2'(i));
    end
    $display("test_volts done");
  endtask

  task automatic test_button_hold();
    @(posedge clk);
    buttonPin <= 1'b0;
    repeat (FILT - 1) @(posedge clk);
    @(negedge clk);
    check({11'h0, buttonDebouncedLevel}, 12'h001);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({11'h0, buttonDebouncedLevel}, 12'h000);
    check({10'h0, activeMode}, 12'h003);
    @(posedge clk);
    buttonPin <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({11'h0, buttonDebouncedLevel}, 12'h001);
    $display("test_button_hold done");
  endtask

  task automatic test_button_mode0();
    reg_host_model_i.writeReg(8'h2F, 8'h0C);
    @(posedge clk);
    buttonPin <= 1'b0;
    repeat (FILT + 3) @(posedge clk);
    @(negedge clk);
    check({10'h0, activeMode}, 12'h000);
    @(posedge clk);
    buttonPin <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({10'h0, activeMode}, 12'h000);
    chkRails(4'h0, 0, 0, 0, 2'h0);
    $display("test_button_mode0 done");
  endtask

  task automatic test_source();
    setMode(1'b0, 1'b0, 1'b0, 2'h0);
    setMode(1'b0, 1'b0, 1'b0, 2'h3);
    check({10'h0, activeMode}, 12'h003);
    setMode(1'b1, 1'b0, 1'b0, 2'h3);
    check({10'h0, activeMode}, 12'h000);
    setMode(1'b1, 1'b0, 1'b1, 2'h3);
    check({10'h0, activeMode}, 12'h002);
    check({11'h0, modeThreeActive}, 12'h000);
    $display("test_source done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_rw();
    test_back_to_back();
    test_pending();
    test_volts();
    test_button_hold();
    test_button_mode0();
    test_source();
    test_done();
  end
endmodule // tb_mode_three_config_regs
